// *** flash_sram_map.svh ***
`ifndef FLASH_SRAM_MAP_SVH
`define FLASH_SRAM_MAP_SVH

// clock and bus timing
`define CLK_PERIOD_NS 100
`define STROBE_NS 150
`define RESET_LOW_NS 500
`define RESET_RECOVER_NS 300
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_LOW_CYC ((`RESET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_RECOVER_CYC ((`RESET_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// widths
`define ADDR_W 21
`define DATA_W 16

// flash command words, neutral defaults
`define CMD_READ_ARRAY 16'h0001
`define CMD_READ_STATUS 16'h0002
`define CMD_PROGRAM 16'h0003
`define CMD_ERASE_SETUP 16'h0004
`define CMD_ERASE_CONFIRM 16'h0005
`define CMD_LOCK_SETUP 16'h0006
`define CMD_LOCK_CONFIRM 16'h0007
`define CMD_UNLOCK_CONFIRM 16'h0008
`define CMD_SUSPEND 16'h0009
`define CMD_RESUME 16'h000a

// status word field
`define STATUS_READY_BIT 0

`endif

// *** flash_sram_pkg.sv ***
package flash_sram_pkg;

   typedef enum logic [3:0] {
      OP_FLASH_READ,
      OP_FLASH_STATUS,
      OP_FLASH_PROGRAM,
      OP_FLASH_ERASE,
      OP_FLASH_LOCK,
      OP_FLASH_UNLOCK,
      OP_FLASH_SUSPEND,
      OP_FLASH_RESUME,
      OP_FLASH_RESET,
      OP_SRAM_READ,
      OP_SRAM_WRITE
   } op_e;

   typedef struct packed {
      logic valid;
      logic wr;
      logic sram;
      logic [15:0] data;
   } cyc_s;

endpackage

// *** pin_cycle.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_sram_map.svh"

module pin_cycle #(
   parameter int STROBE_CYC = `STROBE_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic is_write,
   input wire logic to_sram,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [`DATA_W-1:0] wdata,
   input wire logic [1:0] lane_n,
   input wire logic [`DATA_W-1:0] dq_in,
   output logic [`ADDR_W-1:0] addr_pin,
   output logic [`DATA_W-1:0] dq_out,
   output logic dq_oe,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic sram_select1_n,
   output logic sram_select2,
   output logic sram_oe_n,
   output logic sram_we_n,
   output logic sram_upper_lane_n,
   output logic sram_lower_lane_n,
   output logic [`DATA_W-1:0] rdata,
   output logic done
);

   typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} phase_e;

   localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC - 1);

   phase_e phase_reg;
   logic [7:0] cnt_reg;
   logic wr_reg;
   logic sram_reg;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= PH_IDLE;
         cnt_reg <= 8'h00;
         wr_reg <= 1'b0;
         sram_reg <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (phase_reg)
            PH_IDLE: begin
               if (start) begin
                  wr_reg <= is_write;
                  sram_reg <= to_sram;
                  phase_reg <= PH_SETUP;
               end
            end
            PH_SETUP: begin
               cnt_reg <= 8'h00;
               phase_reg <= PH_STROBE;
            end
            PH_STROBE: begin
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == STROBE_LAST) begin
                  phase_reg <= PH_HOLD;
               end
            end
            PH_HOLD: begin
               done <= 1'b1;
               phase_reg <= PH_IDLE;
            end
         endcase
      end
   end

   // address and write data stay put from setup through hold
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_pin <= '0;
         dq_out <= '0;
         sram_upper_lane_n <= 1'b1;
         sram_lower_lane_n <= 1'b1;
      end else if (phase_reg == PH_IDLE && start) begin
         addr_pin <= addr;
         dq_out <= wdata;
         sram_upper_lane_n <= lane_n[1];
         sram_lower_lane_n <= lane_n[0];
      end else if (phase_reg == PH_HOLD) begin
         sram_upper_lane_n <= 1'b1;
         sram_lower_lane_n <= 1'b1;
      end
   end

   // strobes and selects
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         sram_select1_n <= 1'b1;
         sram_select2 <= 1'b0;
         sram_oe_n <= 1'b1;
         sram_we_n <= 1'b1;
         dq_oe <= 1'b0;
      end else begin
         unique case (phase_reg)
            PH_IDLE: begin
               flash_ce_n <= !(start && !to_sram);
               sram_select1_n <= !(start && to_sram);
               sram_select2 <= start && to_sram;
               dq_oe <= start && is_write;
            end
            PH_SETUP: begin
               flash_we_n <= !(wr_reg && !sram_reg);
               flash_oe_n <= !(!wr_reg && !sram_reg);
               sram_we_n <= !(wr_reg && sram_reg);
               sram_oe_n <= !(!wr_reg && sram_reg);
            end
            PH_STROBE: begin
               if (cnt_reg == STROBE_LAST) begin
                  flash_we_n <= 1'b1;
                  flash_oe_n <= 1'b1;
                  sram_we_n <= 1'b1;
                  sram_oe_n <= 1'b1;
               end
            end
            PH_HOLD: begin
               flash_ce_n <= 1'b1;
               sram_select1_n <= 1'b1;
               sram_select2 <= 1'b0;
               dq_oe <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (phase_reg == PH_STROBE && cnt_reg == STROBE_LAST && !wr_reg) begin
         rdata <= dq_in;
      end
   end

   a_data_at_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(flash_we_n) |-> dq_oe && !flash_ce_n)
      else $error("write data not held at write strobe rise");

   a_read_floats: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!flash_oe_n || !sram_oe_n) |-> !dq_oe)
      else $error("host drives data bus during a read");

   a_cycle_ends: assert property (@(posedge core_clk) disable iff (!rst_n)
      (phase_reg == PH_IDLE && start) |-> ##[3:40] done)
      else $error("bus cycle did not finish in time");

endmodule
`default_nettype wire

// *** flash_sram_host.sv ***
// Functional notes
// - program or erase is started by two bus writes; launch after the second.
// - host may suspend program or erase, then read other blocks; the host polls program and erase to ready before it takes a suspend.
// - host resets flash by driving the reset pin low, also at system reset.
// - program data sits on the data bus in the second write cycle.
`timescale 1ns/1ps
`default_nettype none
`include "flash_sram_map.svh"

module flash_sram_host
   import flash_sram_pkg::*;
#(
   parameter int STROBE_CYC = `STROBE_CYC,
   parameter logic [15:0] CMD_READ_ARRAY = `CMD_READ_ARRAY,
   parameter logic [15:0] CMD_READ_STATUS = `CMD_READ_STATUS,
   parameter logic [15:0] CMD_PROGRAM = `CMD_PROGRAM,
   parameter logic [15:0] CMD_ERASE_SETUP = `CMD_ERASE_SETUP,
   parameter logic [15:0] CMD_ERASE_CONFIRM = `CMD_ERASE_CONFIRM,
   parameter logic [15:0] CMD_LOCK_SETUP = `CMD_LOCK_SETUP,
   parameter logic [15:0] CMD_LOCK_CONFIRM = `CMD_LOCK_CONFIRM,
   parameter logic [15:0] CMD_UNLOCK_CONFIRM = `CMD_UNLOCK_CONFIRM,
   parameter logic [15:0] CMD_SUSPEND = `CMD_SUSPEND,
   parameter logic [15:0] CMD_RESUME = `CMD_RESUME,
   parameter int READY_BIT = `STATUS_READY_BIT
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire op_e cmd_op,
   input wire logic [`ADDR_W-1:0] cmd_addr,
   input wire logic [`DATA_W-1:0] cmd_wdata,
   input wire logic [1:0] cmd_lane_n,
   input wire logic lockdown_protect,
   output logic cmd_ready,
   output logic cmd_done,
   output logic [`DATA_W-1:0] cmd_rdata,
   input wire logic [`DATA_W-1:0] dq_in,
   output logic [`DATA_W-1:0] dq_out,
   output logic dq_oe,
   output logic [`ADDR_W-1:0] addr,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic flash_reset_powerdown_n,
   output logic flash_wp_n,
   output logic sram_select1_n,
   output logic sram_select2,
   output logic sram_oe_n,
   output logic sram_we_n,
   output logic sram_upper_lane_n,
   output logic sram_lower_lane_n
);

   typedef enum logic [2:0] {
      ST_RST_LOW, ST_RST_REC, ST_IDLE, ST_ISSUE, ST_WAIT, ST_POLL, ST_POLL_WAIT, ST_TAIL_WAIT
   } state_e;

   localparam logic [7:0] RST_LOW_LAST = 8'(`RESET_LOW_CYC - 1);
   localparam logic [7:0] RST_REC_LAST = 8'(`RESET_RECOVER_CYC - 1);

   state_e state_reg;
   op_e op_reg;
   logic [`ADDR_W-1:0] addr_reg;
   logic [`DATA_W-1:0] data_reg;
   logic [1:0] lane_reg;
   logic [1:0] step_reg;
   logic [7:0] rst_cnt_reg;
   logic start_reg;
   logic start_wr_reg;
   logic start_sram_reg;
   logic [`DATA_W-1:0] start_data_reg;
   logic cyc_done;
   logic [`DATA_W-1:0] cyc_rdata;
   cyc_s step_c;

   // bus cycle list of each operation; valid low ends the list
   function automatic cyc_s step_cycle(op_e op, logic [1:0] step, logic [15:0] wd);
      cyc_s c;
      c = '{valid: 1'b0, wr: 1'b1, sram: 1'b0, data: 16'h0000};
      unique case (op)
         OP_FLASH_READ: begin
            c.valid = (step < 2'd2);
            c.wr = (step == 2'd0);
            c.data = CMD_READ_ARRAY;
         end
         OP_FLASH_STATUS: begin
            c.valid = (step < 2'd2);
            c.wr = (step == 2'd0);
            c.data = CMD_READ_STATUS;
         end
         OP_FLASH_PROGRAM: begin
            c.valid = (step < 2'd2);
            c.data = (step == 2'd0) ? CMD_PROGRAM : wd;
         end
         OP_FLASH_ERASE: begin
            c.valid = (step < 2'd2);
            c.data = (step == 2'd0) ? CMD_ERASE_SETUP : CMD_ERASE_CONFIRM;
         end
         OP_FLASH_LOCK: begin
            c.valid = (step < 2'd2);
            c.data = (step == 2'd0) ? CMD_LOCK_SETUP : CMD_LOCK_CONFIRM;
         end
         OP_FLASH_UNLOCK: begin
            c.valid = (step < 2'd2);
            c.data = (step == 2'd0) ? CMD_LOCK_SETUP : CMD_UNLOCK_CONFIRM;
         end
         OP_FLASH_SUSPEND: begin
            c.valid = (step == 2'd0);
            c.data = CMD_SUSPEND;
         end
         OP_FLASH_RESUME: begin
            c.valid = (step == 2'd0);
            c.data = CMD_RESUME;
         end
         OP_SRAM_READ: begin
            c.valid = (step == 2'd0);
            c.wr = 1'b0;
            c.sram = 1'b1;
         end
         OP_SRAM_WRITE: begin
            c.valid = (step == 2'd0);
            c.sram = 1'b1;
            c.data = wd;
         end
         default: c.valid = 1'b0;
      endcase
      return c;
   endfunction

   function automatic logic needs_poll(op_e op);
      return op == OP_FLASH_PROGRAM || op == OP_FLASH_ERASE || op == OP_FLASH_SUSPEND;
   endfunction

   assign step_c = step_cycle(op_reg, step_reg, data_reg);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_RST_LOW;
         op_reg <= OP_FLASH_READ;
         addr_reg <= '0;
         data_reg <= '0;
         lane_reg <= 2'b11;
         step_reg <= 2'd0;
         rst_cnt_reg <= 8'h00;
         start_reg <= 1'b0;
         start_wr_reg <= 1'b0;
         start_sram_reg <= 1'b0;
         start_data_reg <= '0;
         cmd_ready <= 1'b0;
         cmd_done <= 1'b0;
         cmd_rdata <= '0;
      end else begin
         start_reg <= 1'b0;
         cmd_done <= 1'b0;
         unique case (state_reg)
            ST_RST_LOW: begin
               rst_cnt_reg <= rst_cnt_reg + 8'h01;
               if (rst_cnt_reg == RST_LOW_LAST) begin
                  rst_cnt_reg <= 8'h00;
                  state_reg <= ST_RST_REC;
               end
            end
            ST_RST_REC: begin
               rst_cnt_reg <= rst_cnt_reg + 8'h01;
               if (rst_cnt_reg == RST_REC_LAST) begin
                  rst_cnt_reg <= 8'h00;
                  cmd_done <= (op_reg == OP_FLASH_RESET);
                  cmd_ready <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (cmd_valid) begin
                  op_reg <= cmd_op;
                  addr_reg <= cmd_addr;
                  data_reg <= cmd_wdata;
                  lane_reg <= cmd_lane_n;
                  step_reg <= 2'd0;
                  cmd_ready <= 1'b0;
                  state_reg <= (cmd_op == OP_FLASH_RESET) ? ST_RST_LOW : ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               if (step_c.valid) begin
                  start_reg <= 1'b1;
                  start_wr_reg <= step_c.wr;
                  start_sram_reg <= step_c.sram;
                  start_data_reg <= step_c.data;
                  state_reg <= ST_WAIT;
               end else if (needs_poll(op_reg)) begin
                  state_reg <= ST_POLL;
               end else begin
                  cmd_done <= 1'b1;
                  cmd_ready <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            ST_WAIT: begin
               if (cyc_done) begin
                  if (!start_wr_reg) begin
                     cmd_rdata <= cyc_rdata;
                  end
                  step_reg <= step_reg + 2'd1;
                  state_reg <= ST_ISSUE;
               end
            end
            ST_POLL: begin
               start_reg <= 1'b1;
               start_wr_reg <= 1'b0;
               start_sram_reg <= 1'b0;
               state_reg <= ST_POLL_WAIT;
            end
            ST_POLL_WAIT: begin
               if (cyc_done) begin
                  if (cyc_rdata[READY_BIT]) begin
                     cmd_rdata <= cyc_rdata;
                     start_reg <= 1'b1;
                     start_wr_reg <= 1'b1;
                     start_data_reg <= CMD_READ_ARRAY;
                     state_reg <= ST_TAIL_WAIT;
                  end else begin
                     state_reg <= ST_POLL;
                  end
               end
            end
            ST_TAIL_WAIT: begin
               if (cyc_done) begin
                  cmd_done <= 1'b1;
                  cmd_ready <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // reset pin low from system reset and during a reset operation
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_reset_powerdown_n <= 1'b0;
      end else begin
         // pin falls in the take cycle so the low time spans the whole reset count
         flash_reset_powerdown_n <= !((state_reg == ST_IDLE && cmd_valid
            && cmd_op == OP_FLASH_RESET)
            || (state_reg == ST_RST_LOW && rst_cnt_reg != RST_LOW_LAST));
      end
   end

   // write protect low holds lock-down marked blocks locked
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_wp_n <= 1'b0;
      end else begin
         flash_wp_n <= !lockdown_protect;
      end
   end

   pin_cycle #(
      .STROBE_CYC(STROBE_CYC)
   ) u_cycle (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .start(start_reg),
      .is_write(start_wr_reg),
      .to_sram(start_sram_reg),
      .addr(addr_reg),
      .wdata(start_data_reg),
      .lane_n(start_sram_reg ? lane_reg : 2'b11),
      .dq_in(dq_in),
      .addr_pin(addr),
      .dq_out(dq_out),
      .dq_oe(dq_oe),
      .flash_ce_n(flash_ce_n),
      .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n),
      .sram_select1_n(sram_select1_n),
      .sram_select2(sram_select2),
      .sram_oe_n(sram_oe_n),
      .sram_we_n(sram_we_n),
      .sram_upper_lane_n(sram_upper_lane_n),
      .sram_lower_lane_n(sram_lower_lane_n),
      .rdata(cyc_rdata),
      .done(cyc_done)
   );

   // helper counters for the checks
   logic we_prev;
   logic [2:0] we_rises;
   logic [7:0] low_run;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         we_prev <= 1'b1;
         we_rises <= 3'd0;
         low_run <= 8'h00;
      end else begin
         we_prev <= flash_we_n;
         if (state_reg == ST_IDLE) begin
            we_rises <= 3'd0;
         end else if (flash_we_n && !we_prev) begin
            we_rises <= we_rises + 3'd1;
         end
         low_run <= flash_reset_powerdown_n ? 8'h00 : low_run + 8'h01;
      end
   end

   a_reset_pulse_len: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(flash_reset_powerdown_n) |-> $past(low_run) >= RST_LOW_LAST)
      else $error("flash reset pulse too short");

   a_two_write_launch: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_reg == ST_POLL && $past(state_reg) == ST_ISSUE
       && (op_reg == OP_FLASH_PROGRAM || op_reg == OP_FLASH_ERASE)) |-> we_rises == 3'd2)
      else $error("program or erase not launched by exactly two writes");

   a_second_write_data: assert property (@(posedge core_clk) disable iff (!rst_n)
      (op_reg == OP_FLASH_PROGRAM && we_rises == 3'd1 && flash_we_n && !we_prev)
      |-> dq_out == data_reg && dq_oe)
      else $error("program word missing on second write");

   a_sram_select: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!sram_we_n || !sram_oe_n) |-> !sram_select1_n && sram_select2)
      else $error("sram strobed while not selected");

   a_one_device: assert property (@(posedge core_clk) disable iff (!rst_n)
      flash_ce_n || (sram_select1_n && !sram_select2))
      else $error("flash and sram selected together");

   a_poll_ready: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cmd_done && needs_poll(op_reg)) |-> cmd_rdata[READY_BIT])
      else $error("operation finished without ready status");

   a_lane_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
      !sram_we_n |-> {sram_upper_lane_n, sram_lower_lane_n} == lane_reg)
      else $error("sram lane enables do not match request");

   c_program: cover property (@(posedge core_clk) disable iff (!rst_n)
      cmd_done && op_reg == OP_FLASH_PROGRAM);
   c_erase: cover property (@(posedge core_clk) disable iff (!rst_n)
      cmd_done && op_reg == OP_FLASH_ERASE);
   c_suspend: cover property (@(posedge core_clk) disable iff (!rst_n)
      cmd_done && op_reg == OP_FLASH_SUSPEND);
   c_sram_write: cover property (@(posedge core_clk) disable iff (!rst_n)
      cmd_done && op_reg == OP_SRAM_WRITE);

endmodule
`default_nettype wire

// *** mem_stack_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_sram_map.svh"
module mem_stack_model (
   input wire logic [20:0] addr,
   input wire logic [15:0] dq_out,
   input wire logic dq_oe,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic flash_reset_powerdown_n,
   input wire logic sram_select1_n,
   input wire logic sram_select2,
   input wire logic sram_oe_n,
   input wire logic sram_we_n,
   input wire logic sram_upper_lane_n,
   input wire logic sram_lower_lane_n,
   output logic [15:0] dq_in
);
   logic [15:0] fl [16];
   logic [15:0] sr [16];
   logic [3:0] lk = '1;
   logic [15:0] pend = '0;
   logic [15:0] last = '0;
   logic busy = 0;
   logic stat = 0;
   wire fsel = !flash_ce_n && flash_reset_powerdown_n;
   wire ssel = !sram_select1_n && sram_select2;
   wire [3:0] a = addr[3:0];
   wire [1:0] blk = addr[3:2];
   wire fdrv = fsel && !flash_oe_n;
   wire sdrv = ssel && !sram_oe_n;
   wire [15:0] fval = stat ? (16'(!busy) << `STATUS_READY_BIT) : fl[a];
   assign dq_in = dq_oe ? dq_out : fdrv ? fval : sdrv ? sr[a] : ~last;
   initial begin
      for (int i = 0; i < 16; i++) begin
         fl[i] = '1;
         sr[i] = '0;
      end
   end
   always @(dq_in) if (fdrv || sdrv || dq_oe) last = dq_in;
   always @(negedge flash_reset_powerdown_n) begin
      busy = 0;
      pend = 0;
   end
   always @(posedge flash_reset_powerdown_n) begin
      lk = '1;
      stat = 0;
   end
   always @(posedge flash_we_n) if (fsel) begin
      if (pend == `CMD_PROGRAM || pend == `CMD_ERASE_SETUP) begin
         if (!lk[blk] && pend == `CMD_PROGRAM) fl[a] = dq_out;
         if (!lk[blk] && pend != `CMD_PROGRAM) for (int i = 0; i < 4; i++) fl[{blk, 2'(i)}] = '1;
         busy = 1;
         stat = 1;
         fork #2000 busy = 0; join_none
         pend = 0;
      end else if (pend == `CMD_LOCK_SETUP) begin
         lk[blk] = (dq_out == `CMD_LOCK_CONFIRM);
         pend = 0;
      end else begin
         pend = dq_out;
         stat = (dq_out != `CMD_READ_ARRAY);
      end
   end
   always @(posedge sram_we_n) if (ssel) begin
      if (!sram_upper_lane_n) sr[a][15:8] = dq_out[15:8];
      if (!sram_lower_lane_n) sr[a][7:0] = dq_out[7:0];
   end
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_sram_map.svh"
module tb;
   import flash_sram_pkg::*;
   logic core_clk = 0;
   logic rst_n = 0;
   logic cmd_valid = 0;
   op_e cmd_op = OP_SRAM_READ;
   logic [20:0] cmd_addr = '0;
   logic [15:0] cmd_wdata = '0;
   logic [1:0] cmd_lane_n = '0;
   logic lockdown_protect = 0;
   logic cmd_ready, cmd_done, dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
   logic flash_reset_powerdown_n, flash_wp_n, sram_select1_n, sram_select2;
   logic sram_oe_n, sram_we_n, sram_upper_lane_n, sram_lower_lane_n;
   logic [15:0] cmd_rdata, dq_in, dq_out, got;
   logic [20:0] addr;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   flash_sram_host uut (.core_clk, .rst_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata,
      .cmd_lane_n, .lockdown_protect, .cmd_ready, .cmd_done, .cmd_rdata, .dq_in, .dq_out,
      .dq_oe, .addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_powerdown_n,
      .flash_wp_n, .sram_select1_n, .sram_select2, .sram_oe_n, .sram_we_n,
      .sram_upper_lane_n, .sram_lower_lane_n);
   mem_stack_model mdl (.addr, .dq_out, .dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n,
      .flash_reset_powerdown_n, .sram_select1_n, .sram_select2, .sram_oe_n, .sram_we_n,
      .sram_upper_lane_n, .sram_lower_lane_n, .dq_in);
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         results;
      end
   end
   task automatic results;
      $display("checks=%0d bad=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic op(input op_e o, input logic [20:0] a, input logic [15:0] d,
         input logic [1:0] l);
      int n;
      n = 0;
      @(negedge core_clk);
      while (cmd_ready !== 1'b1 && n < 99) begin
         n++;
         @(negedge core_clk);
      end
      cmd_op = o;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_lane_n = l;
      cmd_valid = 1;
      @(negedge core_clk);
      cmd_valid = 0;
      while (cmd_done !== 1'b1 && n < 999) begin
         n++;
         @(posedge core_clk);
         #1;
      end
      chk(16'(cmd_done), 16'h1);
      got = cmd_rdata;
   endtask
   task automatic rd(input logic [20:0] a, input logic [15:0] e);
      op(OP_FLASH_READ, a, 16'h0, 2'b00);
      chk(got, e);
   endtask
   task automatic t_sram;
      op(OP_SRAM_WRITE, 21'h5, 16'h1234, 2'b00);
      op(OP_SRAM_WRITE, 21'h5, 16'habcd, 2'b01);
      op(OP_SRAM_READ, 21'h5, 16'h0, 2'b00);
      chk(got, 16'hab34);
      op(OP_SRAM_WRITE, 21'h5, 16'h5566, 2'b10);
      op(OP_SRAM_READ, 21'h5, 16'h0, 2'b00);
      chk(got, 16'hab66);
      $display("test sram done");
   endtask
   task automatic t_prog;
      op(OP_FLASH_PROGRAM, 21'h1, 16'h0f0f, 2'b00);
      rd(21'h1, 16'hffff);
      op(OP_FLASH_UNLOCK, 21'h1, 16'h0, 2'b00);
      op(OP_FLASH_PROGRAM, 21'h1, 16'h0f0f, 2'b00);
      chk(16'(got[`STATUS_READY_BIT]), 16'h1);
      rd(21'h1, 16'h0f0f);
      rd(21'h2, 16'hffff);
      op(OP_FLASH_LOCK, 21'h1, 16'h0, 2'b00);
      op(OP_FLASH_PROGRAM, 21'h2, 16'h1111, 2'b00);
      rd(21'h2, 16'hffff);
      $display("test program done");
   endtask
   task automatic t_erase;
      op(OP_FLASH_UNLOCK, 21'h6, 16'h0, 2'b00);
      op(OP_FLASH_PROGRAM, 21'h6, 16'h00aa, 2'b00);
      op(OP_FLASH_ERASE, 21'h4, 16'h0, 2'b00);
      rd(21'h6, 16'hffff);
      rd(21'h1, 16'h0f0f);
      op(OP_FLASH_SUSPEND, 21'h4, 16'h0, 2'b00);
      chk(16'(got[`STATUS_READY_BIT]), 16'h1);
      op(OP_FLASH_UNLOCK, 21'h8, 16'h0, 2'b00);
      op(OP_FLASH_PROGRAM, 21'h9, 16'h0055, 2'b00);
      rd(21'h9, 16'h0055);
      op(OP_FLASH_RESUME, 21'h4, 16'h0, 2'b00);
      op(OP_FLASH_STATUS, 21'h0, 16'h0, 2'b00);
      chk(16'(got[`STATUS_READY_BIT]), 16'h1);
      $display("test erase done");
   endtask
   task automatic t_reset;
      op(OP_FLASH_RESET, 21'h0, 16'h0, 2'b00);
      op(OP_FLASH_PROGRAM, 21'h7, 16'h2222, 2'b00);
      rd(21'h7, 16'hffff);
      @(negedge core_clk);
      lockdown_protect = 1;
      repeat (2) @(negedge core_clk);
      chk(16'(flash_wp_n), 16'h0);
      lockdown_protect = 0;
      repeat (2) @(negedge core_clk);
      chk(16'(flash_wp_n), 16'h1);
      $display("test reset done");
   endtask
   initial begin
      repeat (6) @(negedge core_clk);
      rst_n = 1;
      t_sram;
      t_prog;
      t_erase;
      t_reset;
      results;
   end
endmodule
`default_nettype wire
